// ---- hw/sem_regs.svh ----
/*
 * register indexes, field positions, reset values and timing counts of the serial rom mode control.
 * assumes a 250 MHz system clock and a 32-bit wishbone register bus (byte address = 4 * index).
 */
// Functional notes
// - mode field bits 7-6 of command register selects operation; zero means normal.
// - writing the auto-load code reloads configuration from the serial rom, as after reset.
// - auto-load takes about two milliseconds before normal operation resumes.
// - on auto-load completion mode returns to normal and other registers to defaults.
// - programming code suspends all network activity and host bus-master transfers.
// - in programming mode bits 3-0 map to chip-select, clock, data-in, data-out pins.
// - configuration registers change only while the write-enable code is set.
// - the four pin bits track pin states in auto-load and programming modes.
// - pin bits are valid only while the flash-select bit is cleared.
// - clock, data-in and data-out bits are valid only after boot rom handling completes.
// - a read-only bit reports whether the attached rom is a larger type.
`ifndef SEM_REGS_SVH
`define SEM_REGS_SVH
// ************************************
// register indexes
// ************************************
`define SEM_IDX_CMD         8'h50
`define SEM_IDX_CFG0        8'h51
`define SEM_IDX_STATUS      8'h54
`define SEM_IDX_CTRL        8'h55
`define SEM_IDX_CFG_USER    8'h56
// ************************************
// fields and codes
// ************************************
`define SEM_MODE_MSB        7
`define SEM_MODE_LSB        6
`define SEM_CS_BIT          3
`define SEM_SK_BIT          2
`define SEM_DI_BIT          1
`define SEM_DO_BIT          0
`define SEM_MODE_NORMAL     2'h0
`define SEM_MODE_AUTOLOAD   2'h1
`define SEM_MODE_PROGRAM    2'h2
`define SEM_MODE_CFG_WE     2'h3
`define SEM_BRS_RST         3'h0
`define SEM_CFG_USER_RST    8'h00
// ************************************
// timing
// ************************************
`define SEM_CLK_PERIOD_NS   4
`define SEM_AUTOLOAD_TIME_NS 2000000
`define SEM_AUTOLOAD_CYCLES (`SEM_AUTOLOAD_TIME_NS / `SEM_CLK_PERIOD_NS)
`define SEM_SK_HALF_NS      500
`define SEM_SK_HALF_CYCLES  (`SEM_SK_HALF_NS / `SEM_CLK_PERIOD_NS)
`define SEM_LOAD_BITS       16
`endif

// ---- hw/sem_pkg.sv ----
/*
 * types shared by the serial rom mode control modules.
 * assumes the constants of sem_regs.svh for widths.
 */
package sem_pkg;
   // top level sequence: start a load, wait for it, run
   typedef enum logic [1:0] {SEM_KICK, SEM_LOAD, SEM_RUN} sem_state_t;

   // complete state of the control block
   typedef struct packed {
      sem_state_t  st;
      logic [1:0]  mode;
      logic        cs;
      logic        sk;
      logic        di;
      logic        flash;
      logic        rom_type;
      logic [2:0]  brs;
      logic [7:0]  cfg;
      logic [15:0] shift;
      logic [4:0]  nbits;
      logic        susp;
      logic        kick;
      logic        ack;
      logic [31:0] dat;
   } sem_ctrl_t;

   // complete state of the load sequencer
   typedef struct packed {
      logic [19:0] cnt;
      logic [15:0] half;
      logic        busy;
      logic        sk;
      logic        sample;
      logic        done;
   } sem_seq_t;

   // one synchroniser bit
   typedef struct packed {
      logic meta;
      logic stable;
   } sem_sync_t;
endpackage

// ---- hw/sem_load_if.sv ----
/*
 * carrier between the control block and its load sequencer.
 * assumes both ends run on the one system clock.
 */
interface sem_load_if;
   logic start;   // request to begin a load, held for two cycles until busy is seen
   logic busy;    // load in progress
   logic sk;      // serial clock level during a load
   logic sample;  // one-cycle pulse at each rising serial clock
   logic done;    // one-cycle pulse when the load time has run out

   modport ctrl (output start, input busy, sk, sample, done);
   modport seq  (input start, output busy, sk, sample, done);
endinterface

// ---- hw/sem_sync.sv ----
/*
 * two flip-flop synchroniser for pin inputs.
 * assumes inputs are asynchronous to clk_sys_i.
 */
module sem_sync #(
   parameter int WIDTH = 2
) (
   // clock and reset
   input  wire logic             clk_sys_i,
   input  wire logic             rst_n_i,
   // pins and synchronised levels
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);
   for (genvar g = 0; g < WIDTH; g++) begin : g_bit
      sem_pkg::sem_sync_t q, d;
      // the first stage is read only by the second
      always_comb begin
         d.meta   = async_i[g];
         d.stable = q.meta;
      end
      always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
         if (!rst_n_i) q <= '0;
         else          q <= d;
      end
      assign sync_o[g] = q.stable;
   end
endmodule // sem_sync

// ---- hw/sem_autoload.sv ----
/*
 * load sequencer: times the reload window and paces the serial rom clock.
 * start is ignored while busy, so a request held into the first busy cycle opens one window.
 */
`include "sem_regs.svh"
module sem_autoload #(
   parameter int LOAD_CYCLES = `SEM_AUTOLOAD_CYCLES,
   parameter int HALF_CYCLES = `SEM_SK_HALF_CYCLES
) (
   input  wire logic clk_sys_i,
   input  wire logic rst_n_i,
   sem_load_if.seq   ld
);
   // counters are 20 and 16 bits wide; larger values would be truncated and end the window or half period early
   if (LOAD_CYCLES < 2 || LOAD_CYCLES > 1048575 || HALF_CYCLES < 1 || HALF_CYCLES > 65535) begin : g_bad_timing
      $error("sem_autoload: timing parameter out of range");
   end
   sem_pkg::sem_seq_t q, d;
   // the window ends by count, not by bit count, so it never outlasts its time
   always_comb begin
      d = q;
      d.sample = 1'b0;
      d.done   = 1'b0;
      if (!q.busy) begin
         if (ld.start) begin
            d.busy = 1'b1;
            d.cnt  = '0;
            d.half = '0;
            d.sk   = 1'b0;
         end
      end else if (q.cnt == 20'(LOAD_CYCLES - 1)) begin
         d.busy = 1'b0;
         d.done = 1'b1;
         d.sk   = 1'b0;
      end else begin
         d.cnt = q.cnt + 20'h00001;
         if (q.half == 16'(HALF_CYCLES - 1)) begin
            d.half   = '0;
            d.sk     = ~q.sk;
            d.sample = ~q.sk;
         end else begin
            d.half = q.half + 16'h0001;
         end
      end
   end
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) q <= '0;
      else          q <= d;
   end
   assign ld.busy   = q.busy;
   assign ld.sk     = q.sk;
   assign ld.sample = q.sample;
   assign ld.done   = q.done;
endmodule // sem_autoload

// ---- hw/sem_mode_ctrl.sv ----
/*
 * serial rom mode control: command register with its four operating modes, direct pin
 * access for programming, a timed reload of configuration from the rom, and the write
 * guard on configuration registers. registers are reached over classic wishbone.
 * assumes the rom pins are plain outputs plus one data-out input from the rom, a
 * rom type strap pin, and a boot rom completion level from logic on the same clock.
 */
`include "sem_regs.svh"
module sem_mode_ctrl #(
   parameter int ADDR_W      = 10,
   parameter int LOAD_CYCLES = `SEM_AUTOLOAD_CYCLES,
   parameter int HALF_CYCLES = `SEM_SK_HALF_CYCLES
) (
   // clock and reset
   input  wire logic        clk_sys_i,
   input  wire logic        rst_n_i,
   // wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [ADDR_W-1:0] wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic             wb_ack_o,
   output logic      [31:0] wb_dat_o,
   // serial rom pins
   output logic             rom_cs_o,
   output logic             rom_sk_o,
   output logic             rom_di_o,
   input  wire logic        rom_do_i,
   // straps and boot rom status
   input  wire logic        rom_type_pin_i,
   input  wire logic        boot_rom_done_i,
   // controls toward the rest of the controller
   output logic             net_suspend_o,
   output logic             dma_suspend_o,
   output logic      [2:0]  boot_rom_size_o,
   output logic      [7:0]  cfg_user_o
);
   // ************************************
   // elaboration checks
   // ************************************
   // the index decode reads address bits 9:2, so narrower buses cannot be served
   if (ADDR_W < 10 || ADDR_W > 32) begin : g_bad_addr_w
      $error("sem_mode_ctrl: ADDR_W must be 10 to 32");
   end

   // ************************************
   // decoding helpers
   // ************************************
   // true when the byte address selects a given register index
   function automatic logic idx_hit(input logic [ADDR_W-1:0] adr, input logic [7:0] idx);
      logic upper_zero;
      upper_zero = 1'b1;
      for (int i = 10; i < ADDR_W; i++) begin
         if (adr[i]) upper_zero = 1'b0;
      end
      idx_hit = upper_zero && (adr[9:2] == idx);
   endfunction

   // true for the modes in which the pin bits follow the pins
   function automatic logic pins_tracked(input logic [1:0] mode);
      pins_tracked = (mode == `SEM_MODE_AUTOLOAD) || (mode == `SEM_MODE_PROGRAM);
   endfunction

   // ************************************
   // pin synchronisers
   // ************************************
   logic [1:0] pin_sync;
   logic       do_s;     // synchronised rom data-out
   logic       type_s;   // synchronised rom type strap

   sem_sync #(
      .WIDTH (2)
   ) u_sync (
      .clk_sys_i (clk_sys_i),
      .rst_n_i   (rst_n_i),
      .async_i   ({rom_type_pin_i, rom_do_i}),
      .sync_o    (pin_sync)
   );

   assign do_s   = pin_sync[0];
   assign type_s = pin_sync[1];

   // ************************************
   // load sequencer
   // ************************************
   sem_load_if ld ();

   sem_autoload #(
      .LOAD_CYCLES (LOAD_CYCLES),
      .HALF_CYCLES (HALF_CYCLES)
   ) u_load (
      .clk_sys_i (clk_sys_i),
      .rst_n_i   (rst_n_i),
      .ld        (ld.seq)
   );

   // ************************************
   // state
   // ************************************
   sem_pkg::sem_ctrl_t q;
   sem_pkg::sem_ctrl_t d;

   // bus request decode
   logic        req;
   logic        wr;
   logic        hit_cmd;
   logic        hit_cfg0;
   logic        hit_status;
   logic        hit_ctrl;
   logic        hit_cfg_user;

   // read-back views
   logic        pin_valid;
   logic        late_valid;
   logic [7:0]  cmd_view;
   logic [7:0]  status_view;
   logic [31:0] rd_word;
   logic [1:0]  new_mode;

   // a request is answered once; the ack gate keeps a held strobe from repeating it
   always_comb begin
      req          = wb_cyc_i && wb_stb_i && !q.ack;
      wr           = req && wb_we_i && wb_sel_i[0];
      hit_cmd      = idx_hit(wb_adr_i, `SEM_IDX_CMD);
      hit_cfg0     = idx_hit(wb_adr_i, `SEM_IDX_CFG0);
      hit_status   = idx_hit(wb_adr_i, `SEM_IDX_STATUS);
      hit_ctrl     = idx_hit(wb_adr_i, `SEM_IDX_CTRL);
      hit_cfg_user = idx_hit(wb_adr_i, `SEM_IDX_CFG_USER);
      new_mode     = wb_dat_i[`SEM_MODE_MSB:`SEM_MODE_LSB];
   end

   // ************************************
   // register read views
   // ************************************
   // pin bits are gated rather than frozen so software never sees a stale pin level
   always_comb begin
      pin_valid  = pins_tracked(q.mode) && !q.flash;
      late_valid = pin_valid && boot_rom_done_i;
      cmd_view   = 8'h00;
      cmd_view[`SEM_MODE_MSB:`SEM_MODE_LSB] = q.mode;
      cmd_view[`SEM_CS_BIT] = pin_valid && q.cs;
      cmd_view[`SEM_SK_BIT] = late_valid && q.sk;
      cmd_view[`SEM_DI_BIT] = late_valid && q.di;
      cmd_view[`SEM_DO_BIT] = late_valid && do_s;
      status_view    = 8'h00;
      status_view[0] = q.rom_type;
      status_view[1] = (q.st != sem_pkg::SEM_RUN);
      status_view[2] = boot_rom_done_i;
      status_view[3] = q.susp;
   end

   // unmapped words read as zero and still get an answer
   always_comb begin
      rd_word = 32'h0000_0000;
      if (hit_cmd)           rd_word[7:0] = cmd_view;
      else if (hit_cfg0)     rd_word[7:0] = {5'h00, q.brs};
      else if (hit_status)   rd_word[7:0] = status_view;
      else if (hit_ctrl)     rd_word[7:0] = {7'h00, q.flash};
      else if (hit_cfg_user) rd_word[7:0] = q.cfg;
   end

   // ************************************
   // next state
   // ************************************
   always_comb begin
      d      = q;
      d.kick = 1'b0;
      d.ack  = req;
      if (req) begin
         d.dat = wb_we_i ? 32'h0000_0000 : rd_word;
      end

      case (q.st)
         // hand the sequencer its start pulse and catch the rom type strap
         sem_pkg::SEM_KICK: begin
            d.kick     = 1'b1;
            d.rom_type = type_s;
            d.mode     = `SEM_MODE_AUTOLOAD;
            d.shift    = '0;
            d.nbits    = '0;
            d.cs       = 1'b1;
            d.sk       = 1'b0;
            d.di       = 1'b0;
            d.susp     = 1'b1;
            if (ld.busy) begin
               d.kick = 1'b0;
               d.st   = sem_pkg::SEM_LOAD;
            end
         end

         // the sequencer drives the clock; rom data-out is shifted in on each of the first 16 rises
         sem_pkg::SEM_LOAD: begin
            d.cs = 1'b1;
            d.sk = ld.sk;
            d.di = 1'b0;
            if (ld.sample && (q.nbits != 5'(`SEM_LOAD_BITS))) begin
               d.shift = {q.shift[14:0], do_s};
               d.nbits = q.nbits + 5'h01;
            end
            if (ld.done) begin
               d.st    = sem_pkg::SEM_RUN;
               d.mode  = `SEM_MODE_NORMAL;
               d.cs    = 1'b0;
               d.sk    = 1'b0;
               d.di    = 1'b0;
               d.flash = 1'b0;
               d.susp  = 1'b0;
               d.brs   = q.shift[2:0];
               d.cfg   = q.shift[15:8];
            end
         end

         // normal running: software owns the command register
         sem_pkg::SEM_RUN: begin
            if (wr && hit_cmd) begin
               d.mode = new_mode;
               case (new_mode)
                  `SEM_MODE_AUTOLOAD: begin
                     d.st = sem_pkg::SEM_KICK;
                  end
                  `SEM_MODE_PROGRAM: begin
                     // data-out bit is an input; its write value is dropped
                     d.cs = wb_dat_i[`SEM_CS_BIT];
                     d.sk = wb_dat_i[`SEM_SK_BIT];
                     d.di = wb_dat_i[`SEM_DI_BIT];
                  end
                  default: begin
                     d.cs = 1'b0;
                     d.sk = 1'b0;
                     d.di = 1'b0;
                  end
               endcase
               d.susp = (new_mode == `SEM_MODE_PROGRAM);
            end
            if (wr && hit_ctrl) begin
               d.flash = wb_dat_i[0];
            end
            // guard against stray writes corrupting the configuration
            if (wr && hit_cfg_user && (q.mode == `SEM_MODE_CFG_WE)) begin
               d.cfg = wb_dat_i[7:0];
            end
         end

         default: begin
            d.st = sem_pkg::SEM_KICK;
         end
      endcase
   end

   // ************************************
   // state register
   // ************************************
   // reset behaves as a bus reset: a reload follows straight after release
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         q          <= '0;
         q.st       <= sem_pkg::SEM_KICK;
         q.mode     <= `SEM_MODE_AUTOLOAD;
         q.susp     <= 1'b1;
         q.brs      <= `SEM_BRS_RST;
         q.cfg      <= `SEM_CFG_USER_RST;
      end else begin
         q <= d;
      end
   end

   // ************************************
   // outputs
   // ************************************
   assign ld.start        = q.kick;
   assign wb_ack_o        = q.ack;
   assign wb_dat_o        = q.dat;
   assign rom_cs_o        = q.cs;
   assign rom_sk_o        = q.sk;
   assign rom_di_o        = q.di;
   assign net_suspend_o   = q.susp;
   assign dma_suspend_o   = q.susp;
   assign boot_rom_size_o = q.brs;
   assign cfg_user_o      = q.cfg;
endmodule // sem_mode_ctrl

// ---- verif/sem_rom_model.sv ----
/*
 * behavioural serial rom: shifts a fixed 16-bit word out, msb first.
 * assumes the controller drives cs, sk and di as plain levels.
 */
module sem_rom_model #(
   parameter logic [15:0] DATA = 16'ha503
) (
   // pins from the controller
   input  wire logic cs_i,
   input  wire logic sk_i,
   input  wire logic di_i,
   // pin to the controller
   output logic      do_o
);
   timeunit 1ns;
   timeprecision 1ps;
   int   idx = 0;
   logic lvl = 1'b0;

   // restart the word at each select; advance on falling clock so rising edges see a settled bit
   always @(posedge cs_i) idx = 0;
   always @(negedge sk_i) if (cs_i) idx++;
   always @* if (cs_i) lvl = (idx < 16) ? DATA[15 - idx] : 1'b0;
   // released line shows the inverse, so a stale level never reads as good
   assign do_o = cs_i ? lvl : ~lvl;
endmodule // sem_rom_model

// ---- verif/sem_mode_ctrl_assertions.sv ----
/*
 * checker for the serial rom mode control, bound to its top module.
 * assumes one clock domain and the register indexes of sem_regs.svh.
 */
`include "sem_regs.svh"
module sem_mode_ctrl_assertions #(
   parameter int ADDR_W = 10
) (
   input wire logic              clk_sys_i,
   input wire logic              rst_n_i,
   input wire logic              wb_cyc_i,
   input wire logic              wb_stb_i,
   input wire logic              wb_we_i,
   input wire logic [ADDR_W-1:0] wb_adr_i,
   input wire logic [3:0]        wb_sel_i,
   input wire logic [31:0]       wb_dat_i,
   input wire logic              wb_ack_o,
   input wire logic [31:0]       wb_dat_o,
   input wire logic              rom_cs_o,
   input wire logic              rom_sk_o,
   input wire logic              rom_di_o,
   input wire logic              rom_do_i,
   input wire logic              rom_type_pin_i,
   input wire logic              boot_rom_done_i,
   input wire logic              net_suspend_o,
   input wire logic              dma_suspend_o,
   input wire logic [2:0]        boot_rom_size_o,
   input wire logic [7:0]        cfg_user_o
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);
   // request taken; command write only counted when no load or programming runs
   logic tk, wr_cmd, wr_usr;
   assign tk     = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wr_cmd = tk && wb_we_i && wb_sel_i[0] && wb_adr_i[9:2] == `SEM_IDX_CMD && !net_suspend_o;
   assign wr_usr = tk && wb_we_i && wb_adr_i[9:2] == `SEM_IDX_CFG_USER;
   // ************************************
   // properties
   // ************************************
   property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
   property p_ack_answer; tk |=> wb_ack_o; endproperty
   a_ack_answer: assert property (p_ack_answer) else $error("request not answered");
   property p_prog_suspend; wr_cmd && wb_dat_i[7:6] == 2'h2 |=> net_suspend_o && dma_suspend_o; endproperty
   a_prog_suspend: assert property (p_prog_suspend) else $error("programming not suspended");
   property p_same_suspend; net_suspend_o == dma_suspend_o; endproperty
   a_same_suspend: assert property (p_same_suspend) else $error("suspends differ");
   property p_prog_pins;
      wr_cmd && wb_dat_i[7:6] == 2'h2 |=> {rom_cs_o, rom_sk_o, rom_di_o} == $past(wb_dat_i[3:1]);
   endproperty
   a_prog_pins: assert property (p_prog_pins) else $error("pins not from written bits");
   property p_load_start;
      wr_cmd && wb_dat_i[7:6] == 2'h1 |=> ##[0:3] (rom_cs_o && !rom_di_o && net_suspend_o);
   endproperty
   a_load_start: assert property (p_load_start) else $error("reload did not start");
   property p_cfg_guard; !$stable(cfg_user_o) |-> $past(net_suspend_o) || $past(wr_usr); endproperty
   a_cfg_guard: assert property (p_cfg_guard) else $error("config changed unguarded");
   property p_brs_load; !$stable(boot_rom_size_o) |-> $past(net_suspend_o) && !net_suspend_o; endproperty
   a_brs_load: assert property (p_brs_load) else $error("boot size changed outside reload");
   property p_pin_gate;
      tk && !wb_we_i && wb_adr_i[9:2] == `SEM_IDX_CMD && !net_suspend_o |=> wb_dat_o[3:0] == 4'h0;
   endproperty
   a_pin_gate: assert property (p_pin_gate) else $error("pin bits outside their modes");
endmodule // sem_mode_ctrl_assertions

bind sem_mode_ctrl sem_mode_ctrl_assertions #(.ADDR_W(ADDR_W)) chk_u (
   .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
   .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .rom_cs_o(rom_cs_o), .rom_sk_o(rom_sk_o),
   .rom_di_o(rom_di_o), .rom_do_i(rom_do_i), .rom_type_pin_i(rom_type_pin_i),
   .boot_rom_done_i(boot_rom_done_i), .net_suspend_o(net_suspend_o), .dma_suspend_o(dma_suspend_o),
   .boot_rom_size_o(boot_rom_size_o), .cfg_user_o(cfg_user_o));

// ---- verif/serial_eeprom_mode_control_test.sv ----
/*
 * self-checking bench of the serial rom mode control with a rom model on its pins.
 * assumes a short reload (400 cycles) so the run stays brief.
 */
`include "sem_regs.svh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_fail++; $display("BAD %0t got %h exp %h", $time, (g), (e)); end end
module serial_eeprom_mode_control_test;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int         LOAD  = 400;
   localparam logic [9:0] A_CMD = {`SEM_IDX_CMD, 2'b00};
   localparam logic [9:0] A_CF0 = {`SEM_IDX_CFG0, 2'b00};
   localparam logic [9:0] A_STA = {`SEM_IDX_STATUS, 2'b00};
   localparam logic [9:0] A_CTL = {`SEM_IDX_CTRL, 2'b00};
   localparam logic [9:0] A_USR = {`SEM_IDX_CFG_USER, 2'b00};
   typedef struct packed {logic [9:0] wa; logic [7:0] wd; logic [9:0] ra; logic [7:0] m; logic [7:0] e;} sem_row_t;
   logic clk_sys, rst_n, cyc, stb, we, ack, cs, sk, di, do_w, type_pin, boot_done, net_s, dma_s;
   logic [9:0]  adr;
   logic [3:0]  sel;
   logic [31:0] dat_w, dat_r;
   logic [2:0]  brs;
   logic [7:0]  usr, q;
   int n_fail = 0, n_compared = 0, cyc_n = 0, t0;
   // write a register, read one back, compare under a mask
   sem_row_t rows [8] = '{'{A_CMD, 8'h8e, A_CMD, 8'hfe, 8'h8e}, '{A_CMD, 8'h0e, A_CMD, 8'hff, 8'h00},
      '{A_USR, 8'h11, A_USR, 8'hff, 8'ha5}, '{A_CMD, 8'hc0, A_CMD, 8'hff, 8'hc0},
      '{A_USR, 8'h11, A_USR, 8'hff, 8'h11}, '{A_CF0, 8'h07, A_CF0, 8'hff, 8'h03},
      '{10'h3fc, 8'hff, 10'h3fc, 8'hff, 8'h00}, '{A_CMD, 8'h00, A_STA, 8'h0f, 8'h05}};

   sem_mode_ctrl #(.LOAD_CYCLES(LOAD), .HALF_CYCLES(4)) dut_u (
      .clk_sys_i(clk_sys), .rst_n_i(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_ack_o(ack), .wb_dat_o(dat_r),
      .rom_cs_o(cs), .rom_sk_o(sk), .rom_di_o(di), .rom_do_i(do_w), .rom_type_pin_i(type_pin),
      .boot_rom_done_i(boot_done), .net_suspend_o(net_s), .dma_suspend_o(dma_s),
      .boot_rom_size_o(brs), .cfg_user_o(usr));
   sem_rom_model #(.DATA(16'ha503)) rom_u (.cs_i(cs), .sk_i(sk), .di_i(di), .do_o(do_w));

   // ************************************
   // clock, cycle count, watchdog
   // ************************************
   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) cyc_n++;
   // whole run needs about 900 cycles; far margin against a hung handshake
   initial begin
      repeat (20000) @(posedge clk_sys);
      n_fail++;
      stop_test;
   end

   task automatic stop_test;
      if (n_fail == 0 && n_compared > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // classic cycle: hold everything until ack is sampled high
   task automatic wb(input logic [9:0] a, input logic w, input logic [7:0] d, output logic [7:0] r);
      int n = 0;
      @(posedge clk_sys);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat_w <= {24'h000000, d};
      do @(posedge clk_sys); while (ack !== 1'b1 && ++n < 100);
      if (n >= 100) n_fail++;
      r = dat_r[7:0];
      cyc <= 1'b0; stb <= 1'b0;
   endtask
   // poll load busy under a bound
   task automatic wait_load;
      int n = 0;
      do begin wb(A_STA, 1'b0, 8'h00, q); n++; end while (q[1] !== 1'b0 && n < 500);
      if (n >= 500) n_fail++;
   endtask

   // ************************************
   // main sequence
   // ************************************
   initial begin
      rst_n = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 10'h000; sel = 4'h1; dat_w = 32'h0;
      type_pin = 1'b1; boot_done = 1'b1;
      repeat (20) @(posedge clk_sys);
      `CHK({ack, cs, sk, di, net_s, dma_s, brs, usr}, {4'h0, 2'b11, 3'h0, 8'h00})
      rst_n <= 1'b1;
      wait_load;
      `CHK({brs, usr}, {3'h3, 8'ha5})
      foreach (rows[i]) begin
         wb(rows[i].wa, 1'b1, rows[i].wd, q);
         wb(rows[i].ra, 1'b0, 8'h00, q);
         `CHK(q & rows[i].m, rows[i].e)
      end
      // selected rom drives its msb; the written data-out bit is ignored
      wb(A_CMD, 1'b1, 8'h88, q);
      `CHK({net_s, dma_s}, 2'b11)
      wb(A_CMD, 0, 8'h00, q);
      `CHK(q, 8'h89)
      wb(A_CTL, 1'b1, 8'h01, q);
      wb(A_CMD, 0, 8'h00, q);
      `CHK(q & 8'h0f, 8'h00)
      wb(A_CTL, 1'b1, 8'h00, q);
      boot_done <= 1'b0;
      wb(A_CMD, 0, 8'h00, q);
      `CHK(q & 8'h0f, 8'h08)
      boot_done <= 1'b1;
      // reload from mode 11 after changing config; a write during the load is refused
      wb(A_CMD, 1'b1, 8'hc0, q);
      wb(A_USR, 1'b1, 8'h33, q);
      type_pin <= 1'b0;
      wb(A_CMD, 1'b1, 8'h40, q);
      t0 = cyc_n;
      wb(A_CMD, 0, 8'h00, q);
      `CHK(q & 8'hc8, 8'h48)
      wb(A_USR, 1'b1, 8'h77, q);
      wb(A_STA, 0, 8'h00, q);
      `CHK(q & 8'h0a, 8'h0a)
      wait_load;
      `CHK((cyc_n - t0 >= LOAD - 5) && (cyc_n - t0 <= LOAD + 20), 1'b1)
      wb(A_CMD, 0, 8'h00, q);
      `CHK(q, 8'h00)
      `CHK({usr, net_s, dma_s}, {8'ha5, 2'b00})
      wb(A_STA, 0, 8'h00, q);
      `CHK(q & 8'h01, 8'h00)
      stop_test;
   end
endmodule // serial_eeprom_mode_control_test
